// >>> phy_strap_pkg.sv
// Purpose: shared constants and carriers for the strap capture block
// Assumes: one 200 MHz reference clock, 16-bit management registers
// Notes: register offsets are 5-bit management addresses
`default_nettype none

package phy_strap_pkg;
	timeunit 1ns;
	timeprecision 100ps;

	// ==========================================================
	// clocking
	localparam int REF_CLK_KHZ = 200000;
	localparam int LINE_CLK_100_KHZ = 25000;
	localparam int LINE_CLK_10_KHZ = 2500;
	// half periods of the line clock, rounded down, at least one
	localparam logic [7:0] HALF_100 = 8'(REF_CLK_KHZ / (2 * LINE_CLK_100_KHZ));
	localparam logic [7:0] HALF_10 = 8'(REF_CLK_KHZ / (2 * LINE_CLK_10_KHZ));

	// ==========================================================
	// register map
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_ADV = 5'h04;
	localparam logic [4:0] REG_STRAP = 5'h10;

	localparam int CTRL_SPEED_BIT = 13;
	localparam int CTRL_NEG_BIT = 12;
	localparam int CTRL_DUPLEX_BIT = 8;
	localparam logic [15:0] CTRL_WMASK = 16'h3100;
	localparam logic [15:0] CTRL_RESET = 16'h3000;

	localparam int ADV_TX_FD_BIT = 8;
	localparam int ADV_TX_HD_BIT = 7;
	localparam int ADV_T_FD_BIT = 6;
	localparam int ADV_T_HD_BIT = 5;
	localparam logic [15:0] ADV_WMASK = 16'h01E0;
	localparam logic [15:0] ADV_RESET = 16'h01E1;

	// strap status register fields
	localparam int ST_ADDR_LSB = 0;
	localparam int ST_MODE_LSB = 5;
	localparam int ST_XOVER_BIT = 8;
	localparam int ST_RSVD_BIT = 9;
	localparam int ST_TEST_BIT = 10;
	localparam int ST_FILT_BIT = 11;
	localparam int ST_UNIQ_BIT = 12;
	localparam int ST_VALID_BIT = 15;

	// ==========================================================
	// strap decoding
	localparam logic [1:0] ADDR_HIGH_BITS = 2'h0;
	localparam logic [2:0] MODE_MII_NOXOVER = 3'h0;
	localparam logic [2:0] MODE_MII_XOVER_A = 3'h2;
	localparam logic [2:0] MODE_MII_XOVER_B = 3'h6;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic [3:0] rxd;
		logic rxDv;
		logic crs;
		logic rxClk;
		logic rxErr;
		logic col;
		logic led0;
		logic led1;
		logic irq;
	} strapPins_s;

	typedef struct packed {
		logic valid;
		logic [4:0] mgmtAddr;
		logic [2:0] modeCode;
		logic autoCrossover;
		logic modeReserved;
		logic negEnable;
		logic speed100;
		logic fullDuplex;
		logic testModeEn;
		logic filterEn;
		logic addrZeroUnique;
	} strapCfg_s;

	typedef enum logic [1:0] {
		ST_SAMPLE = 2'b01,
		ST_RUN = 2'b10
	} strapState_e;

endpackage

`default_nettype wire

// >>> bit_sync2.sv
// Purpose: two-stage synchroniser for a bundle of pin levels
// Assumes: each bit is an independent level
// Notes: no reset, so it keeps tracking the pins while chip reset is low
`default_nettype none

module bit_sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic ref_clk,
	input wire logic [WIDTH-1:0] async,
	output logic [WIDTH-1:0] synced
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [WIDTH-1:0] meta;

	// ==========================================================
	// first stage is read only by the second stage
	always_ff @(posedge ref_clk) begin
		meta <= async;
		synced <= meta;
	end

endmodule

`default_nettype wire

// >>> phy_strap_latch.sv
// Purpose: strap capture at reset release, pin turnaround, MII timing
// Assumes: pins pass through bit_sync2 before use; regs on a plain port
// Notes: straps are taken once per reset, then pins become outputs
//
// Notes on behaviour
// (RL1) All strap pins are sampled at reset release and set the config.
// (RL2) Strap pins are inputs during reset and driven outputs afterwards, irq only while irqActive.
// (RL3) Address bits 2..0 come from three straps, bits 4..3 stay zero.
// (RL4) With pull levels only, the management address is 00001.
// (RL5) Mode 000 is MII without crossover, 010/110 with it, others reserved.
// (RL6) Mode bits 0,1,2 come from rx clock, carrier sense, rx valid pins.
// (RL7) The negotiation strap high enables it and loads control bit 12.
// (RL8) The speed strap high picks 100 Mbps and loads control bit 13.
// (RL9) The speed strap also sets the advertised 100 Mbps abilities.
// (RL10) The duplex strap is inverted into control bit 8; high is half.
// (RL11) The test-mode strap low enables the pin-chain test mode.
// (RL12) The filter strap high disables the emission filter.
// (RL13) The broadcast strap low makes address 0 a broadcast address.
// (RL14) Rx data follow the rx clock and are valid only with rx valid.
// (RL15) Tx data are taken on the tx clock and only while tx enable is high.
// (RL16) Latched straps hold until the next chip reset.
`default_nettype none

module phy_strap_latch
	import phy_strap_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	// dual-purpose pins: input, output, output enable
	input wire phy_strap_pkg::strapPins_s pinIn,
	output phy_strap_pkg::strapPins_s pinOut,
	output phy_strap_pkg::strapPins_s pinOe,
	// transmit side pins: clock out to the MAC, enable and data from it
	output logic txClkPin,
	input wire logic txEnPin,
	input wire logic [3:0] txDataPin,
	// core side of the receive path
	input wire logic [3:0] rxData,
	input wire logic rxValid,
	input wire logic rxError,
	input wire logic carrierIn,
	input wire logic collisionIn,
	input wire logic led0On,
	input wire logic led1On,
	input wire logic irqActive,
	output logic rxTaken,
	// core side of the transmit path
	output logic [3:0] txNibble,
	output logic txNibbleValid,
	// latched configuration
	output phy_strap_pkg::strapCfg_s strapCfg,
	// register port
	input wire logic [4:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [15:0] regRdata
);

	// time units only so benches mixing with this block agree on scale
	timeunit 1ns;
	timeprecision 100ps;
	import phy_strap_pkg::*;

	// ==========================================================
	// pin synchronisers
	strapPins_s pinSync;
	logic [4:0] txSync;

	bit_sync2 #(
		.WIDTH($bits(strapPins_s))
	) strapSync (
		.ref_clk(ref_clk),
		.async(pinIn),
		.synced(pinSync)
	);

	bit_sync2 #(
		.WIDTH(5)
	) txPinSync (
		.ref_clk(ref_clk),
		.async({txEnPin, txDataPin}),
		.synced(txSync)
	);

	// ==========================================================
	// strap phase
	strapState_e state_q;
	strapCfg_s cfg_q;
	strapCfg_s cfg_d;
	logic captureNow;

	assign captureNow = (state_q == ST_SAMPLE);

	// sampling runs on the first edge after release; pins are still
	// undriven then because the enables only rise on that same edge
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_SAMPLE;
		end else begin
			case (state_q)
				ST_SAMPLE: state_q <= ST_RUN;
				ST_RUN: state_q <= ST_RUN;
				default: state_q <= ST_SAMPLE;
			endcase
		end
	end

	// decode of the synchronised pin levels
	always_comb begin
		cfg_d = '0;
		cfg_d.valid = 1'b1;
		// address bits 2,1,0 on rxd1, rxd2, rxd3
		cfg_d.mgmtAddr = {ADDR_HIGH_BITS, pinSync.rxd[1], pinSync.rxd[2],
			pinSync.rxd[3]}; // [RL3] [RL4]
		cfg_d.modeCode = {pinSync.rxDv, pinSync.crs, pinSync.rxClk}; // [RL6]
		case (cfg_d.modeCode)
			MODE_MII_NOXOVER: begin
				cfg_d.autoCrossover = 1'b0; // [RL5]
				cfg_d.modeReserved = 1'b0;
			end
			MODE_MII_XOVER_A, MODE_MII_XOVER_B: begin
				cfg_d.autoCrossover = 1'b1; // [RL5]
				cfg_d.modeReserved = 1'b0;
			end
			default: begin
				cfg_d.autoCrossover = 1'b0;
				cfg_d.modeReserved = 1'b1; // [RL5]
			end
		endcase
		cfg_d.negEnable = pinSync.led0; // [RL7]
		cfg_d.speed100 = pinSync.led1; // [RL8]
		cfg_d.fullDuplex = ~pinSync.rxd[0]; // [RL10]
		cfg_d.testModeEn = ~pinSync.irq; // [RL11]
		cfg_d.filterEn = ~pinSync.rxErr; // [RL12]
		cfg_d.addrZeroUnique = pinSync.col; // [RL13]
	end

	// one capture per reset; later pin activity is ignored
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q <= '0;
		end else if (captureNow) begin
			cfg_q <= cfg_d; // [RL1]
		end
	end // [RL16]

	// exported as is; users must qualify it with the valid bit
	assign strapCfg = cfg_q;

	// ==========================================================
	// management registers
	logic [15:0] ctrl_q;
	logic [15:0] adv_q;
	logic [15:0] strapStat;

	// control: straps load once, software may change later
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= CTRL_RESET;
		end else if (captureNow) begin
			ctrl_q <= CTRL_RESET;
			ctrl_q[CTRL_NEG_BIT] <= cfg_d.negEnable; // [RL7]
			ctrl_q[CTRL_SPEED_BIT] <= cfg_d.speed100; // [RL8]
			ctrl_q[CTRL_DUPLEX_BIT] <= cfg_d.fullDuplex; // [RL10]
		end else if (regWrite && regAddr == REG_CTRL) begin
			ctrl_q <= (regWdata & CTRL_WMASK) | (ctrl_q & ~CTRL_WMASK);
		end
	end

	// advertisement: a 10 Mbps strap withdraws the 100 Mbps abilities
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			adv_q <= ADV_RESET;
		end else if (captureNow) begin
			adv_q <= ADV_RESET;
			adv_q[ADV_TX_FD_BIT] <= cfg_d.speed100; // [RL9]
			adv_q[ADV_TX_HD_BIT] <= cfg_d.speed100; // [RL9]
		end else if (regWrite && regAddr == REG_ADV) begin
			adv_q <= (regWdata & ADV_WMASK) | (adv_q & ~ADV_WMASK);
		end
	end

	// read-only view of what was strapped
	always_comb begin
		strapStat = '0;
		strapStat[ST_ADDR_LSB +: 5] = cfg_q.mgmtAddr;
		strapStat[ST_MODE_LSB +: 3] = cfg_q.modeCode;
		strapStat[ST_XOVER_BIT] = cfg_q.autoCrossover;
		strapStat[ST_RSVD_BIT] = cfg_q.modeReserved;
		strapStat[ST_TEST_BIT] = cfg_q.testModeEn;
		strapStat[ST_FILT_BIT] = cfg_q.filterEn;
		strapStat[ST_UNIQ_BIT] = cfg_q.addrZeroUnique;
		strapStat[ST_VALID_BIT] = cfg_q.valid;
	end

	// read data only in the cycle after the strobe, zero otherwise
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			regRdata <= '0;
		end else if (regRead) begin
			case (regAddr)
				REG_CTRL: regRdata <= ctrl_q;
				REG_ADV: regRdata <= adv_q;
				REG_STRAP: regRdata <= strapStat;
				default: regRdata <= '0;
			endcase
		end else begin
			regRdata <= '0;
		end
	end

	// ==========================================================
	// line clock divider, rate from the control speed bit
	logic [7:0] phaseCnt_q;
	logic [7:0] halfLen;
	logic lineClk_q;
	logic phaseEnd;
	logic running;

	assign running = (state_q == ST_RUN);
	assign halfLen = ctrl_q[CTRL_SPEED_BIT] ? HALF_100 : HALF_10;
	assign phaseEnd = running && (phaseCnt_q >= halfLen - 8'h01);

	// a speed change takes effect in the current half period; a shorter one ends it at once
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			phaseCnt_q <= 8'h00;
		end else if (!running || phaseEnd) begin
			phaseCnt_q <= 8'h00;
		end else begin
			phaseCnt_q <= phaseCnt_q + 8'h01;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			lineClk_q <= 1'b0;
		end else if (phaseEnd) begin
			lineClk_q <= ~lineClk_q;
		end
	end

	logic lineRise;
	logic lineFall;

	// single-cycle strobes at the internal line clock edges
	assign lineRise = phaseEnd && !lineClk_q;
	assign lineFall = phaseEnd && lineClk_q;

	// ==========================================================
	// receive path: data change on the falling half so the MAC
	// samples stable nibbles on the rising edge
	logic [3:0] rxd_q;
	logic rxDv_q;
	logic rxEr_q;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rxd_q <= 4'h0;
			rxDv_q <= 1'b0;
			rxEr_q <= 1'b0;
		end else if (lineFall) begin
			rxDv_q <= rxValid; // [RL14]
			rxd_q <= rxValid ? rxData : 4'h0; // [RL14]
			rxEr_q <= rxValid & rxError;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rxTaken <= 1'b0;
		end else begin
			rxTaken <= lineFall && rxValid;
		end
	end

	// ==========================================================
	// transmit path: MAC moves data at our rising edge, we take it
	// half a period later, well past the two sync stages
	// leaves one cycle ahead of the rx clock pin, which is re-registered
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			txClkPin <= 1'b0;
		end else if (lineRise) begin
			txClkPin <= 1'b1;
		end else if (lineFall) begin
			txClkPin <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			txNibble <= 4'h0;
			txNibbleValid <= 1'b0;
		end else begin
			txNibbleValid <= lineFall && txSync[4]; // [RL15]
			if (lineFall && txSync[4]) begin
				txNibble <= txSync[3:0]; // [RL15]
			end
		end
	end

	// ==========================================================
	// pin turnaround: no drive during reset, outputs once sampled
	strapPins_s out_d;

	always_comb begin
		out_d = '0;
		out_d.rxd = rxd_q;
		out_d.rxDv = rxDv_q;
		out_d.crs = carrierIn;
		out_d.rxClk = lineClk_q;
		out_d.rxErr = rxEr_q;
		out_d.col = collisionIn;
		out_d.led0 = ~led0On; // leds are active low
		out_d.led1 = ~led1On;
		out_d.irq = 1'b0; // open-drain style, only pulls low
	end

	// every pin leaves straight from a flop, so no glitches reach the MAC
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pinOut <= '0;
		end else begin
			pinOut <= out_d;
		end
	end

	// enables rise on the capture edge, after the sample is taken
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pinOe <= '0; // [RL2]
		end else begin
			pinOe <= '1; // [RL2]
			pinOe.irq <= irqActive;
		end
	end

endmodule

`default_nettype wire

// >>> phy_strap_latch_sva.sv
// Purpose: port checks for the strap capture block
// Assumes: one clock, async active-low reset
// Notes: attached by bind from the bench
`default_nettype none
module phy_strap_latch_chk (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire phy_strap_pkg::strapPins_s pinOut,
	input wire phy_strap_pkg::strapPins_s pinOe,
	input wire logic txEnPin,
	input wire logic [3:0] txDataPin,
	input wire logic [3:0] rxData,
	input wire logic rxValid,
	input wire logic irqActive,
	input wire logic rxTaken,
	input wire logic [3:0] txNibble,
	input wire logic txNibbleValid,
	input wire phy_strap_pkg::strapCfg_s strapCfg,
	input wire logic [4:0] regAddr,
	input wire logic regRead,
	input wire logic [15:0] regRdata
);
	timeunit 1ns;
	timeprecision 100ps;
	import phy_strap_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// ==========================================================
	// capture and pin turnaround
	wake_up_a: assert property (rst_n && !$past(rst_n) |=>
		strapCfg.valid && pinOe[11:1] == 11'h7FF)
		else $error("no capture or turnaround after reset");
	irq_drive_a: assert property ($past(rst_n) |->
		pinOe.irq == $past(irqActive)) else $error("irq enable wrong");
	cfg_hold_a: assert property (strapCfg.valid |=> $stable(strapCfg))
		else $error("latched straps changed");
	addr_high_a: assert property (strapCfg.valid |->
		strapCfg.mgmtAddr[4:3] == 2'h0) else $error("address high bits");
	xover_mode_a: assert property (strapCfg.valid |->
		strapCfg.autoCrossover == (strapCfg.modeCode inside {3'h2, 3'h6}))
		else $error("crossover decode wrong");
	rsvd_mode_a: assert property (strapCfg.valid |->
		strapCfg.modeReserved == !(strapCfg.modeCode inside {3'h0, 3'h2, 3'h6}))
		else $error("reserved decode wrong");
	// read data of the status register mirrors the latched mode and address fields
	status_rd_a: assert property ($past(regRead) &&
		$past(regAddr) == REG_STRAP |->
		regRdata[7:0] == {strapCfg.modeCode, strapCfg.mgmtAddr})
		else $error("status read wrong");
	// ==========================================================
	// mii nibble timing
	rx_nibble_a: assert property (rxTaken |=>
		pinOut.rxDv == $past(rxValid, 2) &&
		pinOut.rxd == ($past(rxValid, 2) ? $past(rxData, 2) : 4'h0))
		else $error("rx nibble on pins wrong");
	tx_take_a: assert property (txNibbleValid |->
		$past(txEnPin, 3) && txNibble == $past(txDataPin, 3))
		else $error("tx nibble taken wrongly");
	cover property (rxTaken && pinOut.rxDv);
	cover property (txNibbleValid);
	cover property (strapCfg.autoCrossover);
endmodule
`default_nettype wire

// >>> mac_model.sv
// Purpose: far side model: strap resistors and a MAC transmitter
// Assumes: MAC launches on the rising tx clock
// Notes: released data lines show the inverse of their last value
`default_nettype none
module mac_model (
	input wire logic txClkPin,
	input wire phy_strap_pkg::strapPins_s pinOut,
	input wire phy_strap_pkg::strapPins_s pinOe,
	input wire phy_strap_pkg::strapPins_s strapLevel,
	input wire logic txGo,
	input wire logic [3:0] txWord,
	output phy_strap_pkg::strapPins_s pinIn,
	output logic txEnPin,
	output logic [3:0] txDataPin
);
	timeunit 1ns;
	timeprecision 100ps;
	import phy_strap_pkg::*;
	// device drive wins, otherwise the pull or strap level shows
	assign pinIn = strapPins_s'((pinOut & pinOe) |
		(strapLevel & ~pinOe));
	initial begin
		txEnPin = 1'b0;
		txDataPin = 4'h0;
	end
	// mac launches on the clock the device supplies
	always @(posedge txClkPin) begin
		txEnPin <= txGo;
		txDataPin <= txGo ? txWord : ~txDataPin;
	end
endmodule
`default_nettype wire

// >>> phy_strap_latch_tb.sv
// Purpose: self-checking bench for strap capture and mii timing
// Assumes: 200 MHz ref_clk, reset held 16 cycles each time
// Notes: every strap pattern but the final inverted one is applied through a fresh reset
`default_nettype none
module phy_strap_latch_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import phy_strap_pkg::*;
	localparam strapPins_s PULL = strapPins_s'(12'h907);
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	strapPins_s pinIn, pinOut, pinOe, strap, s;
	strapCfg_s strapCfg, c;
	logic txClkPin, txEnPin, txGo = 1'b0, rxValid = 1'b0;
	logic rxTaken, txNibbleValid, regWrite = 1'b0, regRead = 1'b0;
	logic [3:0] txDataPin, txWord = 4'h0, rxData = 4'h0, txNibble;
	logic [5:0] misc = 6'h00;
	logic [4:0] regAddr = 5'h00;
	logic [15:0] regWdata = 16'h0000, regRdata;
	int mismatches = 0, compares = 0, n;
	always #2.5 ref_clk = ~ref_clk;
	phy_strap_latch phy_strap_latch_inst (.ref_clk(ref_clk), .rst_n(rst_n),
		.pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .txClkPin(txClkPin),
		.txEnPin(txEnPin), .txDataPin(txDataPin), .rxData(rxData),
		.rxValid(rxValid), .rxError(misc[0]), .carrierIn(misc[1]),
		.collisionIn(misc[2]), .led0On(misc[3]), .led1On(misc[4]),
		.irqActive(misc[5]), .rxTaken(rxTaken), .txNibble(txNibble),
		.txNibbleValid(txNibbleValid), .strapCfg(strapCfg),
		.regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
		.regRead(regRead), .regRdata(regRdata));
	mac_model mac_model_inst (.txClkPin(txClkPin), .pinOut(pinOut),
		.pinOe(pinOe), .strapLevel(strap), .txGo(txGo), .txWord(txWord),
		.pinIn(pinIn), .txEnPin(txEnPin), .txDataPin(txDataPin));
	// ==========================================================
	// helpers
	task automatic complete_run;
		$display("mismatches=%0d compares=%0d", mismatches, compares);
		if (mismatches == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge ref_clk);
		regWrite <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		@(posedge ref_clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRead <= 1'b0;
		#1;
		chk(32'(regRdata), 32'(e));
	endtask
	// pins must stay steady through the sync depth before release
	task automatic do_reset(input strapPins_s lv);
		@(posedge ref_clk);
		rst_n <= 1'b0;
		strap <= lv;
		repeat (16) @(posedge ref_clk);
		chk(32'(pinOe), 32'h0);
		rst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
	endtask
	task automatic check_cfg(input strapPins_s lv);
		logic [2:0] m;
		m = {lv.rxDv, lv.crs, lv.rxClk};
		c.valid = 1'b1;
		c.mgmtAddr = {2'h0, lv.rxd[1], lv.rxd[2], lv.rxd[3]};
		c.modeCode = m;
		c.autoCrossover = (m == 3'h2) || (m == 3'h6);
		c.modeReserved = !(m == 3'h0 || c.autoCrossover);
		c.negEnable = lv.led0;
		c.speed100 = lv.led1;
		c.fullDuplex = !lv.rxd[0];
		c.testModeEn = !lv.irq;
		c.filterEn = !lv.rxErr;
		c.addrZeroUnique = lv.col;
		chk(32'(strapCfg), 32'(c));
		rd(REG_CTRL, {2'h0, c.speed100, c.negEnable, 3'h0, c.fullDuplex,
			8'h00});
		rd(REG_ADV, (ADV_RESET & 16'hFE7F) |
			{7'h00, {2{c.speed100}}, 7'h00});
		rd(REG_STRAP, {c.valid, 2'h0, c.addrZeroUnique, c.filterEn,
			c.testModeEn, c.modeReserved, c.autoCrossover, m,
			c.mgmtAddr});
	endtask
	// ==========================================================
	// tests
	initial begin
		strap = PULL;
		do_reset(PULL);
		chk(32'(strapCfg.mgmtAddr), 32'h1);
		for (int i = 0; i < 8; i++) begin
			s = PULL;
			{s.rxDv, s.crs, s.rxClk} = 3'(i);
			s.rxd = {3'(i), i[0]};
			{s.rxErr, s.col} = {i[1], i[2]};
			{s.led0, s.led1, s.irq} = ~{i[0], i[1], i[2]};
			do_reset(s);
			check_cfg(s);
		end
		do_reset(PULL);
		misc <= 6'h3F;
		strap <= ~PULL;
		wr(REG_STRAP, 16'h0000);
		wr(5'h1F, 16'hFFFF);
		rd(5'h1F, 16'h0000);
		chk(32'(pinOe), 32'hFFF);
		chk(32'({pinOut.crs, pinOut.col, pinOut.led0, pinOut.led1,
			pinOut.irq}), 32'h18);
		check_cfg(PULL);
		wr(REG_CTRL, 16'hFFFF);
		rd(REG_CTRL, CTRL_WMASK);
		// receive: valid nibble then idle nibble
		@(posedge ref_clk);
		rxValid <= 1'b1;
		rxData <= 4'hA;
		for (n = 0; n < 200 && rxTaken !== 1'b1; n++) @(posedge ref_clk) #1;
		chk(32'(rxTaken), 32'h1);
		@(posedge ref_clk);
		rxValid <= 1'b0;
		#1;
		chk(32'({pinOut.rxd, pinOut.rxDv}), 32'h15);
		// idle nibble: no take, pins show idle one line period later
		repeat (2 * int'(HALF_100)) @(posedge ref_clk);
		#1;
		chk(32'({rxTaken, pinOut.rxd, pinOut.rxDv}), 32'h0);
		// transmit one nibble, then idle for a while
		@(posedge ref_clk);
		txGo <= 1'b1;
		txWord <= 4'h5;
		for (n = 0; n < 200 && txNibbleValid !== 1'b1; n++)
			@(posedge ref_clk) #1;
		chk(32'(txNibbleValid), 32'h1);
		chk(32'(txNibble), 32'h5);
		@(posedge ref_clk);
		txGo <= 1'b0;
		// tx clock pin high for exactly one half period at 100 Mbps
		@(posedge txClkPin) #1;
		repeat (int'(HALF_100) - 1) @(posedge ref_clk);
		#1;
		chk(32'(txClkPin), 32'h1);
		@(posedge ref_clk) #1;
		chk(32'(txClkPin), 32'h0);
		repeat (100) @(posedge ref_clk);
		complete_run();
	end
	// cut a hang short well past the expected run time
	initial begin
		#100000;
		mismatches++;
		complete_run();
	end
endmodule
bind phy_strap_latch phy_strap_latch_chk phy_strap_latch_chk_inst (
	.ref_clk(ref_clk), .rst_n(rst_n), .pinOut(pinOut), .pinOe(pinOe),
	.txEnPin(txEnPin), .txDataPin(txDataPin), .rxData(rxData),
	.rxValid(rxValid), .irqActive(irqActive), .rxTaken(rxTaken),
	.txNibble(txNibble), .txNibbleValid(txNibbleValid),
	.strapCfg(strapCfg), .regAddr(regAddr), .regRead(regRead),
	.regRdata(regRdata));
`default_nettype wire
